// File: design/xexec_pkg.sv
// Purpose: Shared constants and types for the extended instruction executor
// Assumes: 8-bit data path, 16-bit program words, byte-wide table pointers
// Notes: Operation codes are local to this block
package xexec_pkg;
    localparam int DATA_W = 8;
    localparam int PROG_W = 16;
    localparam int PADDR_W = 15;
    localparam int BIT_SEL_W = 3;
    localparam int OP_W = 5;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [PADDR_W-9:0] LAST_PAGE = 7'h7f;
    localparam logic [PADDR_W-1:0] PAGE_MASK = 15'h7f00;
    localparam int NIB_W = 4;
    localparam int SIGN_BIT = 7;

    // Operations carried out by the executor
    typedef enum logic [OP_W-1:0]
    {
        OP_NONE,
        OP_SBC_MEM,
        OP_SUB_ACC,
        OP_SUB_MEM,
        OP_DSZ,
        OP_DSZ_ACC,
        OP_SET_BYTE,
        OP_SET_BIT,
        OP_ISZ,
        OP_ISZ_ACC,
        OP_SNZ_BIT,
        OP_SNZ_BYTE,
        OP_SWAP,
        OP_SWAP_ACC,
        OP_SZ_BYTE,
        OP_SZ_MOVE,
        OP_SZ_BIT,
        OP_TRD_CUR,
        OP_TRD_LAST,
        OP_ITRD,
        OP_ITRD_LAST,
        OP_XOR_ACC,
        OP_XOR_MEM
    } op_t;

    // Arithmetic flag set
    typedef struct packed
    {
        logic ov;
        logic z;
        logic ac;
        logic c;
        logic sc;
        logic cz;
    } flags_t;
endpackage

// File: design/xexec_alu_if.sv
`timescale 1ns/1ps
// Purpose: Carries operands and results between executor and its ALU
// Assumes: Combinational ALU
// Notes: One modport per side
interface xexec_alu_if;
    xexec_pkg::op_t op;
    logic [7:0] acc;
    logic [7:0] mem;
    logic [2:0] bit_sel;
    logic carry_in;
    logic z_in;
    logic [7:0] result;
    xexec_pkg::flags_t flags;
    logic skip;
    logic res_zero;
    modport exec (output op, acc, mem, bit_sel, carry_in, z_in,
                  input result, flags, skip, res_zero);
    modport alu (input op, acc, mem, bit_sel, carry_in, z_in,
                 output result, flags, skip, res_zero);
endinterface

// File: design/xexec_alu.sv
`timescale 1ns/1ps
// Purpose: Result, flag and skip computation for each operation
// Assumes: Pure combinational logic
// Notes: Flags not touched by an operation are left for the caller to hold
module xexec_alu
(
    // Operand and result bundle
    xexec_alu_if.alu a
);
    // Subtract core: acc - mem - borrow
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic borrow;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic [7:0] swp;
    logic bit_v;

    // Bit pick used by the bit skip operations
    function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
        pick = v[s];
    endfunction

    always_comb
    begin
        borrow = (a.op == xexec_pkg::OP_SBC_MEM) ? ~a.carry_in : 1'b0;
        diff = {1'b0, a.acc} - {1'b0, a.mem} - {8'h00, borrow};
        ldiff = {1'b0, a.acc[3:0]} - {1'b0, a.mem[3:0]} - {4'h0, borrow};
        dec_v = a.mem - xexec_pkg::ONE_BYTE;
        inc_v = a.mem + xexec_pkg::ONE_BYTE;
        swp = {a.mem[xexec_pkg::NIB_W-1:0], a.mem[7:xexec_pkg::NIB_W]};
        bit_v = pick(a.mem, a.bit_sel);
        a.result = a.mem;
        a.skip = 1'b0;
        a.flags = '0;
        unique case (a.op)
            xexec_pkg::OP_SBC_MEM, xexec_pkg::OP_SUB_ACC, xexec_pkg::OP_SUB_MEM:
            begin
                a.result = diff[7:0];
                a.flags.c = ~diff[8];
                a.flags.ac = ~ldiff[4];
                a.flags.ov = (a.acc[7] ^ a.mem[7]) & (a.acc[7] ^ diff[7]);
                a.flags.z = (diff[7:0] == xexec_pkg::ZERO_BYTE);
                a.flags.sc = a.flags.ov ^ diff[xexec_pkg::SIGN_BIT];
                // Chained zero keeps prior zero only when borrow chain is used
                a.flags.cz = (a.op == xexec_pkg::OP_SBC_MEM) ?
                    (a.flags.z & a.z_in) : a.flags.z;
            end
            xexec_pkg::OP_DSZ, xexec_pkg::OP_DSZ_ACC:
            begin
                a.result = dec_v;
                a.skip = (dec_v == xexec_pkg::ZERO_BYTE);
            end
            xexec_pkg::OP_ISZ, xexec_pkg::OP_ISZ_ACC:
            begin
                a.result = inc_v;
                a.skip = (inc_v == xexec_pkg::ZERO_BYTE);
            end
            xexec_pkg::OP_SET_BYTE: a.result = xexec_pkg::ALL_ONES;
            xexec_pkg::OP_SET_BIT:
                a.result = a.mem | (xexec_pkg::ONE_BYTE << a.bit_sel);
            xexec_pkg::OP_SNZ_BIT: a.skip = bit_v;
            xexec_pkg::OP_SNZ_BYTE: a.skip = (a.mem != xexec_pkg::ZERO_BYTE);
            xexec_pkg::OP_SWAP, xexec_pkg::OP_SWAP_ACC: a.result = swp;
            xexec_pkg::OP_SZ_BYTE, xexec_pkg::OP_SZ_MOVE:
                a.skip = (a.mem == xexec_pkg::ZERO_BYTE);
            xexec_pkg::OP_SZ_BIT: a.skip = ~bit_v;
            xexec_pkg::OP_XOR_ACC, xexec_pkg::OP_XOR_MEM:
            begin
                a.result = a.acc ^ a.mem;
                a.flags.z = ((a.acc ^ a.mem) == xexec_pkg::ZERO_BYTE);
            end
            default: a.result = a.mem;
        endcase
        a.res_zero = (a.result == xexec_pkg::ZERO_BYTE);
    end
endmodule // xexec_alu

// File: design/xexec_top.sv
// ==========================================================
// Purpose: Executes a subset of extended data-memory instructions
// Assumes: Operand already read from data memory; program memory answers
//          within the cycle of its read strobe
// Notes: Skips insert one dummy cycle into the fetch stream
// What this block does
// - Borrow subtract, result to memory, six flags
// - Subtract to acc or memory; carry means no borrow
// - Decrement memory, skip when result zero
// - Decrement into acc, memory kept, skip zero
// - Byte set writes all ones, flags kept
// - Bit set touches only selected bit
// - Increment memory, skip when result zero
// - Increment into acc, memory kept, skip zero
// - Skip when selected bit is one
// - Skip when memory byte is nonzero
// - Taken skip adds one dummy fetch cycle
// - Swap nibbles of memory byte in place
// - Swapped nibbles go to acc, memory kept
// - Skip when memory byte is zero
// - Copy byte to acc, skip if zero
// - Skip when selected bit is zero
// - Table read current page: low to memory
// - Table read last page: low to memory
// - Bump pointer low, read full pointer address
// - Bump pointer low, read last page
// - XOR into acc, zero flag only
// - XOR into memory, zero flag only
`timescale 1ns/1ps
module xexec_top
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Instruction issue
    input wire logic issue,
    input wire xexec_pkg::op_t op_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [7:0] mem_operand,
    input wire logic [14:0] cur_pc,
    // Program memory port
    output logic prog_rd_r,
    output logic [14:0] prog_addr_r,
    input wire logic [15:0] prog_data,
    // Data memory write-back
    output logic mem_wr_r,
    output logic [7:0] mem_wdata_r,
    // Architectural state
    output logic [7:0] accumulator_reg,
    output xexec_pkg::flags_t flags_r,
    output logic [7:0] table_pointer_low,
    input wire logic [7:0] table_pointer_high,
    output logic [7:0] table_read_high_byte,
    // Sequencer
    output logic skip_r,
    output logic dummy_r,
    output logic busy_r
);
    typedef enum logic [1:0] {S_IDLE, S_TBL, S_DUMMY} st_t;
    st_t st_r;
    st_t st_nxt;
    xexec_alu_if alu_bus ();
    xexec_pkg::op_t op_r;
    logic is_tbl;
    logic is_inc_tbl;
    logic is_last;
    logic [7:0] ptr_eff;

    // Classify table ops
    function automatic logic tbl_op(input xexec_pkg::op_t o);
        tbl_op = (o == xexec_pkg::OP_TRD_CUR) || (o == xexec_pkg::OP_TRD_LAST)
            || (o == xexec_pkg::OP_ITRD) || (o == xexec_pkg::OP_ITRD_LAST);
    endfunction

    // Operations whose result lands in the accumulator
    function automatic logic to_acc(input xexec_pkg::op_t o);
        to_acc = (o == xexec_pkg::OP_SUB_ACC) || (o == xexec_pkg::OP_DSZ_ACC)
            || (o == xexec_pkg::OP_ISZ_ACC) || (o == xexec_pkg::OP_SWAP_ACC)
            || (o == xexec_pkg::OP_SZ_MOVE) || (o == xexec_pkg::OP_XOR_ACC);
    endfunction

    // Operations whose result is written to memory
    function automatic logic to_mem(input xexec_pkg::op_t o);
        to_mem = (o == xexec_pkg::OP_SBC_MEM) || (o == xexec_pkg::OP_SUB_MEM)
            || (o == xexec_pkg::OP_DSZ) || (o == xexec_pkg::OP_ISZ)
            || (o == xexec_pkg::OP_SET_BYTE) || (o == xexec_pkg::OP_SET_BIT)
            || (o == xexec_pkg::OP_SWAP) || (o == xexec_pkg::OP_XOR_MEM);
    endfunction

    // Flag-updating groups
    function automatic logic arith_op(input xexec_pkg::op_t o);
        arith_op = (o == xexec_pkg::OP_SBC_MEM) || (o == xexec_pkg::OP_SUB_ACC)
            || (o == xexec_pkg::OP_SUB_MEM);
    endfunction

    // Operand hookup to the ALU
    assign alu_bus.op = op_in;
    assign alu_bus.acc = accumulator_reg;
    assign alu_bus.mem = mem_operand;
    assign alu_bus.bit_sel = bit_sel_in;
    assign alu_bus.carry_in = flags_r.c;
    assign alu_bus.z_in = flags_r.cz;

    xexec_alu u_alu
    (
        .a(alu_bus)
    );

    assign is_tbl = issue && (st_r == S_IDLE) && tbl_op(op_in);
    assign is_inc_tbl = (op_in == xexec_pkg::OP_ITRD) || (op_in == xexec_pkg::OP_ITRD_LAST);
    assign is_last = (op_in == xexec_pkg::OP_TRD_LAST) || (op_in == xexec_pkg::OP_ITRD_LAST);
    // Pointer after optional pre-increment
    assign ptr_eff = is_inc_tbl ? table_pointer_low + xexec_pkg::ONE_BYTE : table_pointer_low;

    // Sequencer state step
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            S_IDLE:
                if (issue && tbl_op(op_in))
                    st_nxt = S_TBL;
                else if (issue && alu_bus.skip)
                    st_nxt = S_DUMMY;
            S_TBL: st_nxt = S_IDLE;
            S_DUMMY: st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= S_IDLE;
        else
            st_r <= st_nxt;
    end

    // Busy, skip and dummy-cycle indications
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            skip_r <= 1'b0;
            dummy_r <= 1'b0;
        end
        else
        begin
            busy_r <= (st_nxt != S_IDLE);
            skip_r <= issue && (st_r == S_IDLE) && !tbl_op(op_in) && alu_bus.skip;
            dummy_r <= (st_nxt == S_DUMMY);
        end
    end

    // Table pointer pre-increment and program memory request
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            table_pointer_low <= xexec_pkg::ZERO_BYTE;
            prog_rd_r <= 1'b0;
            prog_addr_r <= '0;
            op_r <= xexec_pkg::OP_NONE;
        end
        else
        begin
            prog_rd_r <= is_tbl;
            if (is_tbl)
            begin
                op_r <= op_in;
                if (is_inc_tbl)
                    table_pointer_low <= ptr_eff;
                if (is_last)
                    prog_addr_r <= {xexec_pkg::LAST_PAGE, ptr_eff};
                else if (op_in == xexec_pkg::OP_ITRD)
                    prog_addr_r <= {table_pointer_high[6:0], ptr_eff};
                else
                    prog_addr_r <= (cur_pc & xexec_pkg::PAGE_MASK) | {7'h00, ptr_eff};
            end
        end
    end

    // Memory write-back from ALU or from table data
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_wr_r <= 1'b0;
            mem_wdata_r <= xexec_pkg::ZERO_BYTE;
            table_read_high_byte <= xexec_pkg::ZERO_BYTE;
        end
        else if (st_r == S_TBL)
        begin
            mem_wr_r <= 1'b1;
            mem_wdata_r <= prog_data[7:0];
            table_read_high_byte <= prog_data[15:8];
        end
        else
        begin
            mem_wr_r <= issue && (st_r == S_IDLE) && to_mem(op_in);
            mem_wdata_r <= alu_bus.result;
        end
    end

    // Accumulator update
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            accumulator_reg <= xexec_pkg::ZERO_BYTE;
        else if (issue && (st_r == S_IDLE) && to_acc(op_in))
            accumulator_reg <= (op_in == xexec_pkg::OP_SZ_MOVE) ? mem_operand
                : alu_bus.result;
    end

    // Flag update: arithmetic sets all six, XOR only zero, others none
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            flags_r <= '0;
        else if (issue && (st_r == S_IDLE))
        begin
            if (arith_op(op_in))
                flags_r <= alu_bus.flags;
            else if ((op_in == xexec_pkg::OP_XOR_ACC) || (op_in == xexec_pkg::OP_XOR_MEM))
                flags_r.z <= alu_bus.res_zero;
        end
    end
endmodule // xexec_top

// File: bench/xexec_assertions.sv
// Purpose: Port-level checks of the extended instruction executor
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to xexec_top after the module
`timescale 1ns/1ps
module xexec_checker
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Issue side
    input wire logic issue,
    input wire xexec_pkg::op_t op_in,
    input wire logic [2:0] bit_sel_in,
    input wire logic [7:0] mem_operand,
    input wire logic [14:0] cur_pc,
    input wire logic [7:0] table_pointer_high,
    // Results and sequencer
    input wire logic prog_rd_r,
    input wire logic [14:0] prog_addr_r,
    input wire logic mem_wr_r,
    input wire logic [7:0] mem_wdata_r,
    input wire logic [7:0] accumulator_reg,
    input wire xexec_pkg::flags_t flags_r,
    input wire logic [7:0] table_pointer_low,
    input wire logic skip_r,
    input wire logic dummy_r,
    input wire logic busy_r
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Sequences and properties
    sequence s_take(xexec_pkg::op_t o);
        issue && !busy_r && op_in == o;
    endsequence
    sequence s_fetch;
        prog_rd_r ##1 (mem_wr_r && !prog_rd_r);
    endsequence
    property p_skip_pulse;
        skip_r |-> dummy_r && busy_r ##1 !skip_r && !dummy_r;
    endproperty
    property p_table_fetch;
        issue && !busy_r && op_in inside {xexec_pkg::OP_TRD_CUR, xexec_pkg::OP_TRD_LAST,
            xexec_pkg::OP_ITRD, xexec_pkg::OP_ITRD_LAST} |=> s_fetch;
    endproperty
    property p_cur_page;
        s_take(xexec_pkg::OP_TRD_CUR) |=>
            prog_addr_r == (($past(cur_pc) & 15'h7f00) | 15'($past(table_pointer_low)));
    endproperty
    property p_last_page;
        s_take(xexec_pkg::OP_TRD_LAST) |=>
            prog_addr_r == (15'h7f00 | 15'($past(table_pointer_low)));
    endproperty
    property p_inc_read;
        s_take(xexec_pkg::OP_ITRD) |=> table_pointer_low == $past(table_pointer_low) + 8'h01
            && prog_addr_r == (((15'($past(table_pointer_high)) << 8) & 15'h7f00)
            | 15'(table_pointer_low));
    endproperty
    property p_set_byte;
        s_take(xexec_pkg::OP_SET_BYTE) |=> mem_wr_r && mem_wdata_r == 8'hff && $stable(flags_r);
    endproperty
    property p_set_bit;
        s_take(xexec_pkg::OP_SET_BIT) |=>
            mem_wdata_r == ($past(mem_operand) | (8'h01 << $past(bit_sel_in)));
    endproperty
    property p_swap_acc;
        s_take(xexec_pkg::OP_SWAP_ACC) |=> !mem_wr_r
            && accumulator_reg == (($past(mem_operand) << 4) | ($past(mem_operand) >> 4));
    endproperty
    property p_dec_skip;
        s_take(xexec_pkg::OP_DSZ) |=> mem_wdata_r == $past(mem_operand) - 8'h01
            && skip_r == ($past(mem_operand) == 8'h01);
    endproperty
    property p_xor_acc;
        s_take(xexec_pkg::OP_XOR_ACC) |=> !mem_wr_r
            && accumulator_reg == ($past(accumulator_reg) ^ $past(mem_operand))
            && flags_r.z == (accumulator_reg == 8'h00) && flags_r.c == $past(flags_r.c);
    endproperty
    a_skip_pulse: assert property (p_skip_pulse)
        else $error("skip pulse malformed");
    a_table_fetch: assert property (p_table_fetch)
        else $error("table fetch order wrong");
    a_cur_page: assert property (p_cur_page)
        else $error("current page address wrong");
    a_last_page: assert property (p_last_page)
        else $error("last page address wrong");
    a_inc_read: assert property (p_inc_read)
        else $error("incremented read wrong");
    a_set_byte: assert property (p_set_byte)
        else $error("byte set wrong");
    a_set_bit: assert property (p_set_bit)
        else $error("bit set wrong");
    a_swap_acc: assert property (p_swap_acc)
        else $error("swap to acc wrong");
    a_dec_skip: assert property (p_dec_skip)
        else $error("decrement skip wrong");
    a_xor_acc: assert property (p_xor_acc)
        else $error("xor to acc wrong");
endmodule // xexec_checker

bind xexec_top xexec_checker u_chk (.clk_sys, .rst_n, .issue, .op_in, .bit_sel_in,
    .mem_operand, .cur_pc, .table_pointer_high, .prog_rd_r, .prog_addr_r, .mem_wr_r,
    .mem_wdata_r, .accumulator_reg, .flags_r, .table_pointer_low, .skip_r, .dummy_r, .busy_r);

// File: bench/prog_mem_model.sv
// Purpose: Program memory answering table reads
// Assumes: Word content is a fixed function of its address
// Notes: Outside a read and its hold cycle the data lines show the inverse of the last value
`timescale 1ns/1ps
module prog_mem_model
(
    // Clock
    input wire logic clk_sys,
    // Read port
    input wire logic rd,
    input wire logic [14:0] addr,
    output logic [15:0] data
);
    logic hold_r = 1'b0;
    logic [14:0] addr_r = 15'h0000;
    logic [15:0] last_r = 16'h0000;
    // ==========================================================
    // Word held for the cycle after the read strobe
    always_ff @(posedge clk_sys)
    begin
        hold_r <= rd;
        if (rd)
            addr_r <= addr;
        last_r <= data;
    end
    // High byte is offset mixed, low byte is page
    always_comb
    begin
        if (rd)
            data = {addr[7:0] ^ 8'h5a, 1'b0, addr[14:8]};
        else if (hold_r)
            data = {addr_r[7:0] ^ 8'h5a, 1'b0, addr_r[14:8]};
        else
            data = ~last_r;
    end
endmodule // prog_mem_model

// File: bench/xexec_top_tb_top.sv
// Purpose: Self-checking bench of the extended instruction executor
// Assumes: Inputs driven at the falling edge
// Notes: Flags and acc are tracked by the bench
`timescale 1ns/1ps
module xexec_top_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic issue = 1'b0;
    xexec_pkg::op_t op_in = xexec_pkg::OP_NONE;
    logic [2:0] bit_sel_in = 3'h0;
    logic [7:0] mem_operand = 8'h00;
    logic [14:0] cur_pc = 15'h1234;
    logic [7:0] table_pointer_high = 8'h85;
    logic [15:0] prog_data;
    logic prog_rd_r, mem_wr_r, skip_r, dummy_r, busy_r;
    logic [14:0] prog_addr_r;
    logic [7:0] mem_wdata_r, accumulator_reg, table_pointer_low, table_read_high_byte;
    xexec_pkg::flags_t flags_r;
    int fails = 0;
    int n_checks = 0;
    logic [7:0] acc_e = 8'h00;
    logic [5:0] flg_e = 6'h00;
    logic [7:0] tpl_e = 8'h00;
    // ==========================================================
    // Clock, device and program memory
    always #12.5 clk_sys = ~clk_sys;
    xexec_top u_dut (.clk_sys, .rst_n, .issue, .op_in, .bit_sel_in, .mem_operand, .cur_pc,
        .prog_rd_r, .prog_addr_r, .prog_data, .mem_wr_r, .mem_wdata_r, .accumulator_reg,
        .flags_r, .table_pointer_low, .table_pointer_high, .table_read_high_byte, .skip_r,
        .dummy_r, .busy_r);
    prog_mem_model u_pmem (.clk_sys(clk_sys), .rd(prog_rd_r), .addr(prog_addr_r),
        .data(prog_data));
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // One data operation, judged at the falling edge after it is taken
    task automatic run(input xexec_pkg::op_t op, input logic [2:0] bs, input logic [7:0] m,
        input logic wr, input logic [7:0] wd, input logic sk);
        @(negedge clk_sys);
        issue = 1'b1;
        op_in = op;
        bit_sel_in = bs;
        mem_operand = m;
        @(negedge clk_sys);
        issue = 1'b0;
        chk("mem_wr_r", 16'(wr), 16'(mem_wr_r));
        if (wr)
            chk("mem_wdata_r", 16'(wd), 16'(mem_wdata_r));
        chk("accumulator_reg", 16'(acc_e), 16'(accumulator_reg));
        chk("flags_r", 16'(flg_e), 16'(flags_r));
        chk("skip_r", 16'(sk), 16'(skip_r));
        chk("dummy_r", 16'(sk), 16'(dummy_r));
        chk("busy_r", 16'(sk), 16'(busy_r));
    endtask
    // One table read, fetch then write-back
    task automatic trd(input xexec_pkg::op_t op, input logic [14:0] a);
        @(negedge clk_sys);
        issue = 1'b1;
        op_in = op;
        @(negedge clk_sys);
        issue = 1'b0;
        chk("prog_addr_r", 16'(a), 16'(prog_addr_r));
        chk("table_pointer_low", 16'(tpl_e), 16'(table_pointer_low));
        chk("prog_rd_r", 16'h0001, 16'(prog_rd_r));
        chk("busy_r", 16'h0001, 16'(busy_r));
        @(negedge clk_sys);
        chk("mem_wr_r", 16'h0001, 16'(mem_wr_r));
        chk("mem_wdata_r", 16'(a[14:8]), 16'(mem_wdata_r));
        chk("table_read_high_byte", 16'(a[7:0] ^ 8'h5a), 16'(table_read_high_byte));
        chk("busy_r", 16'h0000, 16'(busy_r));
    endtask
    task automatic t_arith();
        acc_e = 8'h10;
        run(xexec_pkg::OP_SZ_MOVE, 3'h0, 8'h10, 1'b0, 8'h00, 1'b0);
        acc_e = 8'hf0;
        flg_e = 6'h0a;
        run(xexec_pkg::OP_SUB_ACC, 3'h0, 8'h20, 1'b0, 8'h00, 1'b0);
        flg_e = 6'h06;
        run(xexec_pkg::OP_SBC_MEM, 3'h0, 8'h0f, 1'b1, 8'he0, 1'b0);
        flg_e = 6'h1c;
        run(xexec_pkg::OP_SBC_MEM, 3'h0, 8'hf0, 1'b1, 8'h00, 1'b0);
        flg_e = 6'h1d;
        run(xexec_pkg::OP_SUB_MEM, 3'h0, 8'hf0, 1'b1, 8'h00, 1'b0);
    endtask
    task automatic t_count();
        run(xexec_pkg::OP_DSZ, 3'h0, 8'h01, 1'b1, 8'h00, 1'b1);
        run(xexec_pkg::OP_DSZ, 3'h0, 8'h00, 1'b1, 8'hff, 1'b0);
        run(xexec_pkg::OP_ISZ, 3'h0, 8'hff, 1'b1, 8'h00, 1'b1);
        acc_e = 8'h00;
        run(xexec_pkg::OP_DSZ_ACC, 3'h0, 8'h01, 1'b0, 8'h00, 1'b1);
        acc_e = 8'h80;
        run(xexec_pkg::OP_ISZ_ACC, 3'h0, 8'h7f, 1'b0, 8'h00, 1'b0);
        acc_e = 8'h00;
        run(xexec_pkg::OP_SZ_MOVE, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1);
    endtask
    task automatic t_bits();
        run(xexec_pkg::OP_SET_BYTE, 3'h0, 8'h12, 1'b1, 8'hff, 1'b0);
        run(xexec_pkg::OP_SET_BIT, 3'h5, 8'h81, 1'b1, 8'ha1, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            run(xexec_pkg::OP_SNZ_BIT, 3'(i), 8'h01 << i, 1'b0, 8'h00, 1'b1);
            run(xexec_pkg::OP_SNZ_BIT, 3'(i), ~(8'h01 << i), 1'b0, 8'h00, 1'b0);
            run(xexec_pkg::OP_SZ_BIT, 3'(i), ~(8'h01 << i), 1'b0, 8'h00, 1'b1);
            run(xexec_pkg::OP_SZ_BIT, 3'(i), 8'h01 << i, 1'b0, 8'h00, 1'b0);
        end
        run(xexec_pkg::OP_SNZ_BYTE, 3'h0, 8'h80, 1'b0, 8'h00, 1'b1);
        run(xexec_pkg::OP_SNZ_BYTE, 3'h0, 8'h00, 1'b0, 8'h00, 1'b0);
        run(xexec_pkg::OP_SZ_BYTE, 3'h0, 8'h00, 1'b0, 8'h00, 1'b1);
        run(xexec_pkg::OP_SZ_BYTE, 3'h0, 8'h01, 1'b0, 8'h00, 1'b0);
    endtask
    task automatic t_swap_xor();
        run(xexec_pkg::OP_SWAP, 3'h0, 8'h3c, 1'b1, 8'hc3, 1'b0);
        acc_e = 8'h5a;
        run(xexec_pkg::OP_SWAP_ACC, 3'h0, 8'ha5, 1'b0, 8'h00, 1'b0);
        acc_e = 8'h55;
        flg_e = 6'h0d;
        run(xexec_pkg::OP_XOR_ACC, 3'h0, 8'h0f, 1'b0, 8'h00, 1'b0);
        flg_e = 6'h1d;
        run(xexec_pkg::OP_XOR_MEM, 3'h0, 8'h55, 1'b1, 8'h00, 1'b0);
    endtask
    task automatic t_table();
        trd(xexec_pkg::OP_TRD_CUR, {cur_pc[14:8], tpl_e});
        trd(xexec_pkg::OP_TRD_LAST, {7'h7f, tpl_e});
        tpl_e = tpl_e + 8'h01;
        trd(xexec_pkg::OP_ITRD, {table_pointer_high[6:0], tpl_e});
        tpl_e = tpl_e + 8'h01;
        trd(xexec_pkg::OP_ITRD_LAST, {7'h7f, tpl_e});
    endtask
    // Issue held through the dummy cycle after a skip is ignored
    task automatic t_refused();
        @(negedge clk_sys);
        issue = 1'b1;
        op_in = xexec_pkg::OP_SZ_BYTE;
        mem_operand = 8'h00;
        @(negedge clk_sys);
        op_in = xexec_pkg::OP_SET_BYTE;
        chk("busy_r", 16'h0001, 16'(busy_r));
        @(negedge clk_sys);
        issue = 1'b0;
        chk("mem_wr_r", 16'h0000, 16'(mem_wr_r));
        chk("dummy_r", 16'h0000, 16'(dummy_r));
        chk("accumulator_reg", 16'(acc_e), 16'(accumulator_reg));
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("outputs in reset", 16'h0000,
            16'({mem_wr_r, skip_r, busy_r, prog_rd_r, accumulator_reg}));
        rst_n = 1'b1;
        t_arith();
        t_count();
        t_bits();
        t_swap_xor();
        t_refused();
        t_table();
        results();
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        results();
    end
endmodule // xexec_top_tb_top
